/* hw/byte_fifo.v */
`timescale 1ns/1ps
`default_nettype none
`include "uart_alias_defs.vh"

module byte_fifo (
  input wire clk,
  input wire reset,
  input wire flush,
  input wire push,
  input wire [7:0] push_data,
  input wire pop,
  output wire [7:0] head_data,
  output wire full,
  output wire empty
);
  reg [7:0] mem [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW-1:0] wr_ptr_q;
  reg [`FIFO_AW-1:0] rd_ptr_q;
  reg [`FIFO_AW:0] count_q;
  wire do_push;
  wire do_pop;

  // a push into a full fifo is dropped, contents kept
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign full = (count_q == `FIFO_DEPTH);
  assign empty = (count_q == 0);
  assign head_data = mem[rd_ptr_q];

  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_q] <= push_data;
    end
  end

  always @(posedge clk) begin
    if (reset || flush) begin
      wr_ptr_q <= {`FIFO_AW{1'b0}};
      rd_ptr_q <= {`FIFO_AW{1'b0}};
      count_q <= {(`FIFO_AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // byte_fifo

`default_nettype wire

/* hw/uart_alias_defs.vh */
`ifndef UART_ALIAS_DEFS_VH
`define UART_ALIAS_DEFS_VH

// alias window: sixteen words, slot 0 up to slot 15
`define ALIAS_BASE 32'h50001130
`define ALIAS_LIMIT 32'h50001170
`define ALIAS_SLOT7 32'h5000114c
`define ALIAS_SLOT8 32'h50001150
`define ALIAS_RESET 16'h0000

// control and status words next to the window
`define LINE_STATUS_ADDR 32'h50001180
`define FIFO_CONTROL_ADDR 32'h50001184
`define IRQ_STATUS_ADDR 32'h50001188
`define IRQ_MASK_ADDR 32'h5000118c

// line status fields
`define LSR_DATA_READY 0
`define LSR_OVERRUN 1
`define LSR_THR_EMPTY 5
`define LSR_TX_IDLE 6

// fifo control fields
`define FCR_FIFO_EN 0
`define FCR_IR_MODE 1

// interrupt fields
`define IRQ_RX_BYTE 0
`define IRQ_OVERRUN 1
`define IRQ_THR_EMPTY 2
`define IRQ_WIDTH 3

// fifo geometry
`define FIFO_DEPTH 16
`define FIFO_AW 4

// 16x oversample tick: 250 MHz / (115200 * 16) rounded
`define OVS_DIV 8'd136
`define OVS_PER_BIT 4'd15
`define OVS_HALF_BIT 4'd7

`endif

/* hw/uart_shadow_rx_tx_alias.v */
// Summary of operation
// R1: alias read returns received byte, low bits
// R2: sixteen word locations alias one buffer
// R3: software trusts read only when data ready
// R4: no fifo: new byte overwrites, flags overrun
// R5: fifo on: read returns oldest fifo entry
// R6: rx fifo full: drop byte, flag overrun
// R7: written byte goes out on line
// R8: software writes only while holding empty
// R9: no fifo: single write clears holding empty
// R10: no fifo: extra write replaces pending byte
// R11: fifo on: accepts writes up to 16
// R12: write to full tx fifo discarded
// R13: bits 15:8 read zero, writes ignored
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_alias_defs.vh"

module uart_shadow_rx_tx_alias (
  input wire clk,
  input wire reset,
  input wire [31:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata,
  input wire sin,
  input wire sir_in,
  output reg sout,
  output reg sir_out_n,
  output wire irq
);
  localparam TX_IDLE = 2'd0;
  localparam TX_START = 2'd1;
  localparam TX_DATA = 2'd2;
  localparam TX_STOP = 2'd3;
  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA = 2'd2;
  localparam RX_STOP = 2'd3;

  // decode
  wire alias_hit;
  wire lsr_hit;
  wire fcr_hit;
  wire ist_hit;
  wire imsk_hit;
  // alias covers sixteen aligned words so bursts land on one buffer
  assign alias_hit = (addr >= `ALIAS_BASE) && (addr < `ALIAS_LIMIT) && (addr[1:0] == 2'b00); // R2
  assign lsr_hit = (addr == `LINE_STATUS_ADDR);
  assign fcr_hit = (addr == `FIFO_CONTROL_ADDR);
  assign ist_hit = (addr == `IRQ_STATUS_ADDR);
  assign imsk_hit = (addr == `IRQ_MASK_ADDR);

  wire alias_rd = rd_en && alias_hit;
  wire alias_wr = wr_en && alias_hit;

  // control
  reg fifo_en_q;
  reg ir_mode_q;
  reg [`IRQ_WIDTH-1:0] irq_mask_q;
  reg [`IRQ_WIDTH-1:0] irq_stat_q;
  wire fifo_flush;
  // switching fifo mode empties both fifos; the rx and tx holding registers keep their bytes
  assign fifo_flush = wr_en && fcr_hit && (wdata[`FCR_FIFO_EN] != fifo_en_q);

  always @(posedge clk) begin
    if (reset) begin
      fifo_en_q <= 1'b0;
      ir_mode_q <= 1'b0;
      irq_mask_q <= {`IRQ_WIDTH{1'b0}};
    end else begin
      if (wr_en && fcr_hit) begin
        fifo_en_q <= wdata[`FCR_FIFO_EN];
        ir_mode_q <= wdata[`FCR_IR_MODE];
      end
      if (wr_en && imsk_hit) begin
        irq_mask_q <= wdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  // pin synchronisers
  reg sin_meta_q;
  reg sin_sync_q;
  reg sir_meta_q;
  reg sir_sync_q;
  always @(posedge clk) begin
    if (reset) begin
      sin_meta_q <= 1'b1;
      sin_sync_q <= 1'b1;
      sir_meta_q <= 1'b0;
      sir_sync_q <= 1'b0;
    end else begin
      sin_meta_q <= sin;
      sin_sync_q <= sin_meta_q;
      sir_meta_q <= sir_in;
      sir_sync_q <= sir_meta_q;
    end
  end
  // infrared: a pulse on the input marks a zero bit
  wire rx_line = ir_mode_q ? ~sir_sync_q : sin_sync_q; // R1

  // oversample tick
  reg [7:0] ovs_cnt_q;
  wire ovs_tick = (ovs_cnt_q == `OVS_DIV - 8'd1);
  always @(posedge clk) begin
    if (reset || ovs_tick) begin
      ovs_cnt_q <= 8'h00;
    end else begin
      ovs_cnt_q <= ovs_cnt_q + 8'h01;
    end
  end

  // receive engine
  reg [1:0] rx_state_q;
  reg [3:0] rx_tick_q;
  reg [2:0] rx_bit_q;
  reg [7:0] rx_shift_q;
  reg rx_done_q;
  always @(posedge clk) begin
    if (reset) begin
      rx_state_q <= RX_IDLE;
      rx_tick_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_shift_q <= 8'h00;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (ovs_tick) begin
        rx_tick_q <= rx_tick_q + 4'h1;
        case (rx_state_q)
          RX_IDLE: begin
            rx_tick_q <= 4'h0;
            if (!rx_line) begin
              rx_state_q <= RX_START;
            end
          end
          RX_START: begin
            if (rx_tick_q == `OVS_HALF_BIT) begin
              rx_tick_q <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_tick_q == `OVS_PER_BIT) begin
              rx_shift_q <= {rx_line, rx_shift_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == 3'h7) begin
                rx_state_q <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_tick_q == `OVS_PER_BIT) begin
              rx_done_q <= 1'b1;
              rx_state_q <= RX_IDLE;
            end
          end
          default: rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

  // receive storage
  wire [7:0] rx_head;
  wire rx_full;
  wire rx_empty;
  reg [7:0] rx_hold_q;
  reg rx_hold_valid_q;
  reg overrun_q;
  wire rx_push = rx_done_q && fifo_en_q;
  wire rx_pop = alias_rd && fifo_en_q; // R5
  // full fifo keeps its contents; byte_fifo drops the push
  wire rx_overrun = rx_done_q && (fifo_en_q ? rx_full : rx_hold_valid_q); // R4 R6
  wire data_ready = fifo_en_q ? !rx_empty : rx_hold_valid_q;

  byte_fifo rx_fifo (
    .clk(clk),
    .reset(reset),
    .flush(fifo_flush),
    .push(rx_push),
    .push_data(rx_shift_q),
    .pop(rx_pop),
    .head_data(rx_head),
    .full(rx_full),
    .empty(rx_empty)
  );

  always @(posedge clk) begin
    if (reset) begin
      rx_hold_q <= 8'h00;
      rx_hold_valid_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      // arrival beats a same-cycle read so the byte is not lost
      if (rx_done_q && !fifo_en_q) begin
        rx_hold_q <= rx_shift_q; // R4
        rx_hold_valid_q <= 1'b1;
      end else if (alias_rd && !fifo_en_q) begin
        rx_hold_valid_q <= 1'b0;
      end
      if (rx_overrun) begin
        overrun_q <= 1'b1; // R4 R6
      end else if (rd_en && lsr_hit) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // transmit storage
  wire [7:0] tx_head;
  wire tx_full;
  wire tx_empty;
  reg [7:0] tx_hold_q;
  reg thr_empty_q;
  wire tx_load;
  // full fifo drops the write silently
  wire tx_push = alias_wr && fifo_en_q; // R11 R12
  wire tx_pop = tx_load && fifo_en_q;
  wire thr_empty = fifo_en_q ? tx_empty : thr_empty_q;

  byte_fifo tx_fifo (
    .clk(clk),
    .reset(reset),
    .flush(fifo_flush),
    .push(tx_push),
    .push_data(wdata[7:0]), // R13
    .pop(tx_pop),
    .head_data(tx_head),
    .full(tx_full),
    .empty(tx_empty)
  );

  always @(posedge clk) begin
    if (reset) begin
      tx_hold_q <= 8'h00;
      thr_empty_q <= 1'b1;
    end else begin
      // a write while still pending simply replaces the byte
      if (alias_wr && !fifo_en_q) begin
        tx_hold_q <= wdata[7:0]; // R10 R13
        thr_empty_q <= 1'b0; // R9
      end else if (tx_load && !fifo_en_q) begin
        thr_empty_q <= 1'b1;
      end
    end
  end

  // transmit engine
  reg [1:0] tx_state_q;
  reg [3:0] tx_tick_q;
  reg [2:0] tx_bit_q;
  reg [7:0] tx_shift_q;
  reg tx_bit_val;
  assign tx_load = ovs_tick && (tx_state_q == TX_IDLE) && !thr_empty && !alias_wr;

  always @(posedge clk) begin
    if (reset) begin
      tx_state_q <= TX_IDLE;
      tx_tick_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_shift_q <= 8'h00;
    end else if (ovs_tick) begin
      tx_tick_q <= tx_tick_q + 4'h1;
      case (tx_state_q)
        TX_IDLE: begin
          tx_tick_q <= 4'h0;
          if (tx_load) begin
            tx_shift_q <= fifo_en_q ? tx_head : tx_hold_q; // R7
            tx_state_q <= TX_START;
          end
        end
        TX_START: begin
          if (tx_tick_q == `OVS_PER_BIT) begin
            tx_bit_q <= 3'h0;
            tx_state_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_tick_q == `OVS_PER_BIT) begin
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q == 3'h7) begin
              tx_state_q <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (tx_tick_q == `OVS_PER_BIT) begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  always @* begin
    case (tx_state_q)
      TX_START: tx_bit_val = 1'b0;
      TX_DATA: tx_bit_val = tx_shift_q[0];
      default: tx_bit_val = 1'b1;
    endcase
  end

  // pins driven from flops; infrared pulses low for each zero bit
  always @(posedge clk) begin
    if (reset) begin
      sout <= 1'b1;
      sir_out_n <= 1'b1;
    end else begin
      sout <= ir_mode_q ? 1'b1 : tx_bit_val; // R7
      sir_out_n <= ir_mode_q ? tx_bit_val : 1'b1; // R7
    end
  end

  // interrupts
  reg thr_empty_prev_q;
  wire [`IRQ_WIDTH-1:0] irq_event;
  assign irq_event[`IRQ_RX_BYTE] = rx_done_q && !rx_overrun;
  assign irq_event[`IRQ_OVERRUN] = rx_overrun;
  assign irq_event[`IRQ_THR_EMPTY] = thr_empty && !thr_empty_prev_q;

  always @(posedge clk) begin
    if (reset) begin
      irq_stat_q <= {`IRQ_WIDTH{1'b0}};
      thr_empty_prev_q <= 1'b1;
    end else begin
      thr_empty_prev_q <= thr_empty;
      // set wins over a write-one clear in the same cycle
      if (wr_en && ist_hit) begin
        irq_stat_q <= (irq_stat_q & ~wdata[`IRQ_WIDTH-1:0]) | irq_event;
      end else begin
        irq_stat_q <= irq_stat_q | irq_event;
      end
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // read data, one cycle after the strobe
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (alias_hit) begin
      rd_mux[7:0] = fifo_en_q ? rx_head : rx_hold_q; // R1 R5 R13
    end else if (lsr_hit) begin
      rd_mux[`LSR_DATA_READY] = data_ready;
      rd_mux[`LSR_OVERRUN] = overrun_q;
      rd_mux[`LSR_THR_EMPTY] = thr_empty;
      rd_mux[`LSR_TX_IDLE] = thr_empty && (tx_state_q == TX_IDLE);
    end else if (fcr_hit) begin
      rd_mux[`FCR_FIFO_EN] = fifo_en_q;
      rd_mux[`FCR_IR_MODE] = ir_mode_q;
    end else if (ist_hit) begin
      rd_mux[`IRQ_WIDTH-1:0] = irq_stat_q;
    end else if (imsk_hit) begin
      rd_mux[`IRQ_WIDTH-1:0] = irq_mask_q;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else if (rd_en) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule // uart_shadow_rx_tx_alias

`default_nettype wire

/* sim/alias_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uart_alias_defs.vh"
module alias_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic sout,
  input wire logic sir_out_n,
  input wire logic irq
);
  localparam int BIT_CLKS = 2176;
  logic ir_q;
  logic [2:0] mask_q;
  logic [15:0] low_q;
  wire in_win = addr >= `ALIAS_BASE && addr < `ALIAS_LIMIT;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // shadow of mode and mask, since the checker cannot see the registers
  always @(posedge clk) begin
    if (reset) begin
      ir_q <= 1'b0;
      mask_q <= 3'h0;
    end else if (wr_en && addr == `FIFO_CONTROL_ADDR) begin
      ir_q <= wdata[`FCR_IR_MODE];
    end else if (wr_en && addr == `IRQ_MASK_ADDR) begin
      mask_q <= wdata[2:0];
    end
    low_q <= (reset || sout) ? 16'h0 : low_q + 16'h1;
  end
  sequence s_alias_rd;
    rd_en && in_win && addr[1:0] == 2'b00;
  endsequence
  sequence s_start_low;
    !sout [*8];
  endsequence
  property p_idle;
    !rd_en |=> rdata == 32'h0;
  endproperty
  property p_alias_hi;
    s_alias_rd |=> rdata[31:8] == 24'h0;
  endproperty
  property p_unalign;
    rd_en && in_win && addr[1:0] != 2'b00 |=> rdata == 32'h0;
  endproperty
  property p_rst;
    $fell(reset) |-> sout && sir_out_n && !irq && rdata == 32'h0;
  endproperty
  property p_ir_sout;
    ir_q && $past(ir_q) |-> sout;
  endproperty
  property p_nrm_ir;
    !ir_q && !$past(ir_q) |-> sir_out_n;
  endproperty
  property p_mask;
    mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq;
  endproperty
  property p_start;
    $fell(sout) |-> s_start_low;
  endproperty
  property p_bit;
    $rose(sout) |-> (low_q % BIT_CLKS) == 0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_alias_hi: assert property (p_alias_hi) else $error("alias upper bits set");
  a_unalign: assert property (p_unalign) else $error("unaligned alias answered");
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  a_ir_sout: assert property (p_ir_sout) else $error("serial out moved in infrared mode");
  a_nrm_ir: assert property (p_nrm_ir) else $error("infrared out moved in normal mode");
  a_mask: assert property (p_mask) else $error("interrupt with mask clear");
  a_start: assert property (p_start) else $error("start bit too short");
  a_bit: assert property (p_bit) else $error("low run not whole bits");
endmodule // alias_monitor
bind uart_shadow_rx_tx_alias alias_monitor i_mon (.clk(clk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sout(sout),
  .sir_out_n(sir_out_n), .irq(irq));
`default_nettype wire

/* sim/line_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  input wire logic clk,
  input wire logic sout,
  input wire logic sir_out_n,
  output logic sin,
  output logic sir_in
);
  localparam int BIT = 2176;
  logic [7:0] got[$];
  initial begin
    sin = 1'b1;
    sir_in = 1'b0;
  end
  // drives both lines; the design listens to the one its mode selects
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      sin <= f[i];
      sir_in <= !f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // the idle line is held high, so the and of both outputs is the bit
  always begin : rx_line
    logic [7:0] b;
    @(negedge (sout & sir_out_n));
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = sout & sir_out_n;
    end
    repeat (BIT) @(posedge clk);
    got.push_back(b);
  end
endmodule // line_partner
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uart_alias_defs.vh"
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic sin;
  logic sir_in;
  logic sout;
  logic sir_out_n;
  logic irq;
  logic [31:0] d;
  logic [31:0] r;
  logic irq_s;
  integer seed;
  int n_mismatch = 0;
  int checked = 0;
  always #2 clk = ~clk;
  uart_shadow_rx_tx_alias i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sin(sin), .sir_in(sir_in), .sout(sout),
    .sir_out_n(sir_out_n), .irq(irq));
  line_partner i_line (.clk(clk), .sout(sout), .sir_out_n(sir_out_n), .sin(sin),
    .sir_in(sir_in));
  function automatic logic [31:0] slot(input logic [31:0] v);
    return `ALIAS_BASE + {26'h0, v[3:0], 2'b00};
  endfunction
  // one idle cycle after each access keeps strobes from being driven twice per step
  task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_en <= we;
    rd_en <= !we;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1 d = rdata;
    irq_s = irq;
    @(posedge clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_tx(input int n);
    for (int k = 0; k < 3000 && i_line.got.size() < n; k++) @(posedge clk);
    check(32'(i_line.got.size()), 32'(n));
  endtask
  task automatic close_out;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    // two back-to-back frame pairs take about 87k cycles; keep the limit below 100k
    repeat (99000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
  initial begin
    seed = 32'h3c39;
    r = $random(seed);
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(0, `ALIAS_SLOT7, r); check(d, {16'h0, `ALIAS_RESET});
    bus(0, `ALIAS_SLOT8, r); check(d, 32'h0);
    bus(0, `ALIAS_SLOT7 + 32'h2, r); check(d, 32'h0);
    bus(0, `LINE_STATUS_ADDR, r); check(d & 32'h21, 32'h20);
    bus(1, `IRQ_MASK_ADDR, 32'h1);
    // two bytes arrive unread while the holding byte is replaced
    fork
      begin
        i_line.send(r[7:0]);
        i_line.send(r[15:8]);
      end
      begin
        bus(1, slot(r), {24'hffffff, r[23:16]});
        repeat (300) @(posedge clk);
        bus(1, slot(r >> 4), ~r);
        bus(0, `LINE_STATUS_ADDR, r); check(d & 32'h20, 32'h0);
        bus(1, `ALIAS_SLOT8, r >> 24);
      end
    join
    bus(0, `LINE_STATUS_ADDR, r); check(d & 32'h3, 32'h3);
    check({31'h0, irq_s}, 32'h1);
    bus(0, slot(r >> 8), r); check(d, {24'h0, r[15:8]});
    bus(1, `IRQ_MASK_ADDR, 32'h0); check({31'h0, irq_s}, 32'h0);
    bus(1, `IRQ_MASK_ADDR, 32'h1); check({31'h0, irq_s}, 32'h1);
    bus(1, `IRQ_STATUS_ADDR, 32'h7); check({31'h0, irq_s}, 32'h0);
    wait_tx(2);
    check({24'h0, i_line.got[0]}, {24'h0, r[23:16]});
    check({24'h0, i_line.got[1]}, {24'h0, r[31:24]});
    // infrared mode with both fifos on
    r = $random(seed);
    bus(1, `FIFO_CONTROL_ADDR, 32'h3);
    fork
      begin
        i_line.send(r[7:0]);
        i_line.send(r[15:8]);
      end
      begin
        bus(1, slot(r), r >> 16);
        bus(1, slot(~r), r >> 24);
        bus(0, `LINE_STATUS_ADDR, r); check(d & 32'h20, 32'h0);
      end
    join
    bus(0, slot(r >> 12), r); check(d, {24'h0, r[7:0]});
    bus(0, slot(r >> 20), r); check(d, {24'h0, r[15:8]});
    wait_tx(4);
    check({24'h0, i_line.got[2]}, {24'h0, r[23:16]});
    check({24'h0, i_line.got[3]}, {24'h0, r[31:24]});
    close_out;
  end
endmodule // tb_top
`default_nettype wire
